// File: core/ppd_dfc_if.sv
// link between the datapath and one pulse generator
`timescale 1ns/1ps
`default_nettype none
interface ppd_dfc_if;
   logic clr;
   logic add_valid;
   ppd_pkg::ppd_dfc_type add_value;
   ppd_pkg::ppd_dfc_type quantum;
   logic pulse_b;
   logic fired;
   modport gen (input clr, input add_valid, input add_value,
      input quantum, output pulse_b, output fired);
   modport src (output clr, output add_valid, output add_value,
      output quantum, input pulse_b, input fired);
endinterface
`default_nettype wire

// File: core/ppd_pkg.sv
// shared constants and types for the power-to-pulse datapath
package ppd_pkg;
   // ---------------------------------------------------------------
   // clock and timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 4;
   localparam int SAMPLE_RATE_HZ = 447437;
   localparam int LPF_CORNER_MILLIHZ = 8900;
   localparam int LPF_SHIFT =
      $clog2((SAMPLE_RATE_HZ * 7) / ((44 * LPF_CORNER_MILLIHZ) / 1000));
   localparam int HPF_SHIFT = 10;
   localparam int PHASE_SHIFT = 6;
   localparam int LOW_PULSE_NS = 1000;
   localparam int CF_PULSE_NS = 400;
   localparam int SUPPLY_FILT_NS = 10000;
   localparam logic [11:0] LOW_PULSE_CYC =
      12'((LOW_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [11:0] CF_PULSE_CYC =
      12'((CF_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [11:0] SUPPLY_FILT_CYC =
      12'((SUPPLY_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   // ---------------------------------------------------------------
   // frequency converter
   // ---------------------------------------------------------------
   localparam int DFC_W = 60;
   localparam logic [59:0] LOW_QUANTUM_BASE = 60'h080_0000_0000_0000;
   localparam logic [3:0] CF_SHIFT_RST = 4'hB;
   localparam logic [3:0] CF_SHIFT_MAX = 4'hB;
   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_POWER = 4'h8;
   localparam logic [3:0] REG_LOWCNT = 4'hC;
   typedef logic [59:0] ppd_dfc_type;
   typedef logic signed [21:0] ppd_cur_type;
   typedef logic signed [37:0] ppd_pwr_type;
endpackage

// File: core/ppd_power_to_pulse.sv
// real-power datapath: gain, hpf, multiply, lpf, pulse outputs
// Functional notes
// - gain selects 00 x1, 01 x2, 10 x8, 11 x16 on current samples
// - high-pass enable input high removes current-channel dc offset
// - phase compensation applied only while high-pass filter is enabled
// - power is current times voltage, single-pole low-pass at 8.9 Hz
// - converter accumulates filtered power; each pulse is one fixed quantum
// - calibration output uses a shorter accumulation, up to 2048x faster
// - supply low keeps the block reset and all pulses quiet
// - supply-low indication is filtered with hysteresis before reset
// - low-rate energy outputs give active-low pulses
// - rate selects set low-rate base from 1.7 Hz to 13.6 Hz
`timescale 1ns/1ps
`default_nettype none
module ppd_power_to_pulse (
   input wire logic REF_CLK,
   input wire logic RST_B,
   input wire logic SAMPLE_VALID,
   input wire logic signed [15:0] CURRENT_CHANNEL,
   input wire logic signed [15:0] VOLTAGE_CHANNEL,
   input wire logic GAIN_SEL_LSB,
   input wire logic GAIN_SEL_MSB,
   input wire logic HPF_ENABLE_SELECT,
   input wire logic RATE_SEL_LSB,
   input wire logic RATE_SEL_MSB,
   input wire logic ANALOG_SUPPLY_RAIL_LOW,
   input wire logic [3:0] REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [31:0] REG_RDATA,
   output logic ENERGY_PULSE_OUT_A_B,
   output logic ENERGY_PULSE_OUT_B_B,
   output logic CALIBRATION_PULSE_OUT_B
);
   logic supply_ok;
   logic clr;
   logic [1:0] gain_code;
   logic [1:0] rate_code;
   ppd_dfc_if lo_if ();
   ppd_dfc_if cal_if ();

   // ---------------------------------------------------------------
   // supply monitor
   // ---------------------------------------------------------------
   ppd_supply_filt u_supply (
      .clk (REF_CLK),
      .rst_b (RST_B),
      .supply_low (ANALOG_SUPPLY_RAIL_LOW),
      .supply_ok (supply_ok)
   );
   // hold the datapath in reset while supply is low
   assign clr = ~supply_ok;
   assign gain_code = {GAIN_SEL_MSB, GAIN_SEL_LSB};
   assign rate_code = {RATE_SEL_MSB, RATE_SEL_LSB};

   // ---------------------------------------------------------------
   // current channel: gain, high-pass, phase compensation
   // ---------------------------------------------------------------
   logic signed [19:0] gained;
   logic signed [20:0] hp_out;
   logic signed [19:0] dc_est;
   logic signed [21:0] ph_diff;
   ppd_pkg::ppd_cur_type ph_comp;
   logic signed [30:0] dc_ff;
   logic signed [30:0] nxt_dc;
   logic signed [20:0] prev_ff;
   logic signed [20:0] nxt_prev;
   ppd_pkg::ppd_cur_type cur_ff;
   ppd_pkg::ppd_cur_type nxt_cur;
   logic signed [15:0] volt_ff;
   logic signed [15:0] nxt_volt;
   logic s1_valid_ff;
   logic nxt_s1_valid;

   always_comb begin
      unique case (gain_code)
         2'b00: gained = 20'(CURRENT_CHANNEL);
         2'b01: gained = 20'(CURRENT_CHANNEL) <<< 1;
         2'b10: gained = 20'(CURRENT_CHANNEL) <<< 3;
         2'b11: gained = 20'(CURRENT_CHANNEL) <<< 4;
      endcase
      // subtract tracked dc level
      // dc level keeps fraction bits so small offsets still decay
      dc_est = 20'(dc_ff >>> ppd_pkg::HPF_SHIFT);
      hp_out = 21'(gained) - 21'(dc_est);
      ph_diff = 22'(hp_out) - 22'(prev_ff);
      ph_comp = 22'(hp_out) - (ph_diff >>> ppd_pkg::PHASE_SHIFT);
      nxt_dc = dc_ff;
      nxt_prev = prev_ff;
      nxt_cur = cur_ff;
      nxt_volt = volt_ff;
      nxt_s1_valid = SAMPLE_VALID;
      if (SAMPLE_VALID) begin
         nxt_volt = VOLTAGE_CHANNEL;
         if (HPF_ENABLE_SELECT) begin
            nxt_dc = dc_ff + 31'(hp_out);
            nxt_prev = hp_out;
            nxt_cur = ph_comp;
         end else begin
            nxt_cur = 22'(gained);
         end
      end
      if (clr) begin
         nxt_dc = '0;
         nxt_prev = '0;
         nxt_cur = '0;
         nxt_volt = '0;
         nxt_s1_valid = 1'b0;
      end
   end
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         dc_ff <= '0;
         prev_ff <= '0;
         cur_ff <= '0;
         volt_ff <= '0;
         s1_valid_ff <= 1'b0;
      end else begin
         dc_ff <= nxt_dc;
         prev_ff <= nxt_prev;
         cur_ff <= nxt_cur;
         volt_ff <= nxt_volt;
         s1_valid_ff <= nxt_s1_valid;
      end
   end

   // ---------------------------------------------------------------
   // multiplier and single-pole low-pass
   // ---------------------------------------------------------------
   ppd_pkg::ppd_pwr_type prod;
   logic signed [38:0] lpf_diff;
   ppd_pkg::ppd_pwr_type lpf_ff;
   ppd_pkg::ppd_pwr_type nxt_lpf;
   logic s2_valid_ff;
   logic nxt_s2_valid;

   always_comb begin
      prod = 38'(cur_ff) * 38'(volt_ff);
      lpf_diff = 39'(prod) - 39'(lpf_ff);
      nxt_lpf = lpf_ff;
      nxt_s2_valid = s1_valid_ff & ~clr;
      if (s1_valid_ff) begin
         nxt_lpf = lpf_ff + 38'(lpf_diff >>> ppd_pkg::LPF_SHIFT);
      end
      if (clr) begin
         nxt_lpf = '0;
      end
   end
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         lpf_ff <= '0;
         s2_valid_ff <= 1'b0;
      end else begin
         lpf_ff <= nxt_lpf;
         s2_valid_ff <= nxt_s2_valid;
      end
   end

   // ---------------------------------------------------------------
   // frequency converters
   // ---------------------------------------------------------------
   logic [3:0] cf_shift_ff;
   logic [3:0] nxt_cf_shift;
   ppd_pkg::ppd_dfc_type pos_power;
   ppd_pkg::ppd_dfc_type low_q;

   always_comb begin
      // negative power is not counted
      pos_power = lpf_ff[37] ? '0 : 60'(lpf_ff[36:0]);
      // binary fraction chosen by rate code
      low_q = ppd_pkg::LOW_QUANTUM_BASE >> rate_code;
   end
   assign lo_if.clr = clr;
   assign lo_if.add_valid = s2_valid_ff;
   assign lo_if.add_value = pos_power;
   assign lo_if.quantum = low_q;
   assign cal_if.clr = clr;
   assign cal_if.add_valid = s2_valid_ff;
   assign cal_if.add_value = pos_power;
   // shorter accumulation for the calibration output
   assign cal_if.quantum = low_q >> cf_shift_ff;

   ppd_pulse_gen #(
      .WIDTH (ppd_pkg::LOW_PULSE_CYC)
   ) u_low (
      .clk (REF_CLK),
      .rst_b (RST_B),
      .dfc (lo_if)
   );
   ppd_pulse_gen #(
      .WIDTH (ppd_pkg::CF_PULSE_CYC)
   ) u_cal (
      .clk (REF_CLK),
      .rst_b (RST_B),
      .dfc (cal_if)
   );

   // ---------------------------------------------------------------
   // output pins
   // ---------------------------------------------------------------
   logic sel_ff;
   logic nxt_sel;
   logic a_ff;
   logic nxt_a;
   logic b_ff;
   logic nxt_b;
   logic cf_ff;
   logic nxt_cf;

   always_comb begin
      // alternate low-rate pulses between the two outputs
      nxt_sel = sel_ff ^ (lo_if.pulse_b & ~(a_ff & b_ff));
      nxt_a = lo_if.pulse_b | sel_ff;
      nxt_b = lo_if.pulse_b | ~sel_ff;
      nxt_cf = cal_if.pulse_b;
      // idle high while held in reset
      if (clr) begin
         nxt_sel = 1'b0;
         nxt_a = 1'b1;
         nxt_b = 1'b1;
         nxt_cf = 1'b1;
      end
   end
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         sel_ff <= 1'b0;
         a_ff <= 1'b1;
         b_ff <= 1'b1;
         cf_ff <= 1'b1;
      end else begin
         sel_ff <= nxt_sel;
         a_ff <= nxt_a;
         b_ff <= nxt_b;
         cf_ff <= nxt_cf;
      end
   end
   assign ENERGY_PULSE_OUT_A_B = a_ff;
   assign ENERGY_PULSE_OUT_B_B = b_ff;
   assign CALIBRATION_PULSE_OUT_B = cf_ff;

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   logic [15:0] low_cnt_ff;
   logic [15:0] nxt_low_cnt;
   logic [31:0] rdata_ff;
   logic [31:0] nxt_rdata;

   always_comb begin
      nxt_cf_shift = cf_shift_ff;
      nxt_low_cnt = low_cnt_ff + {15'h0000, lo_if.fired};
      nxt_rdata = 32'h0000_0000;
      if (REG_WR && REG_ADDR == ppd_pkg::REG_CTRL) begin
         if (REG_WDATA[3:0] > ppd_pkg::CF_SHIFT_MAX) begin
            nxt_cf_shift = ppd_pkg::CF_SHIFT_MAX;
         end else begin
            nxt_cf_shift = REG_WDATA[3:0];
         end
      end
      // a pulse in the clearing cycle is kept, not lost
      if (REG_WR && REG_ADDR == ppd_pkg::REG_LOWCNT) begin
         nxt_low_cnt = {15'h0000, lo_if.fired};
      end
      if (REG_RD) begin
         unique case (REG_ADDR)
            ppd_pkg::REG_CTRL: nxt_rdata = {28'h0, cf_shift_ff};
            ppd_pkg::REG_STATUS: nxt_rdata = {26'h0, rate_code,
               gain_code, HPF_ENABLE_SELECT, supply_ok};
            ppd_pkg::REG_POWER: nxt_rdata = lpf_ff[37:6];
            ppd_pkg::REG_LOWCNT: nxt_rdata = {16'h0000, low_cnt_ff};
            default: nxt_rdata = 32'h0000_0000;
         endcase
      end
   end
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         cf_shift_ff <= ppd_pkg::CF_SHIFT_RST;
         low_cnt_ff <= 16'h0000;
         rdata_ff <= 32'h0000_0000;
      end else begin
         cf_shift_ff <= nxt_cf_shift;
         low_cnt_ff <= nxt_low_cnt;
         rdata_ff <= nxt_rdata;
      end
   end
   assign REG_RDATA = rdata_ff;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   chk_gain_sixteen: assert property (
      @(posedge REF_CLK) disable iff (!RST_B)
      SAMPLE_VALID && supply_ok && gain_code == 2'b11 && !HPF_ENABLE_SELECT
      |=> cur_ff == 22'($past(CURRENT_CHANNEL)) * 22'sh10)
      else $error("gain of sixteen not applied");
   chk_hpf_bypass: assert property (
      @(posedge REF_CLK) disable iff (!RST_B)
      SAMPLE_VALID && supply_ok && !HPF_ENABLE_SELECT
      |=> $stable(dc_ff) && $stable(prev_ff))
      else $error("filter state moved while bypassed");
   chk_dc_tracks: assert property (
      @(posedge REF_CLK) disable iff (!RST_B)
      SAMPLE_VALID && supply_ok && HPF_ENABLE_SELECT && gained > dc_est
      |=> dc_ff >= $past(dc_ff))
      else $error("dc estimate moved away from input");
   chk_lpf_hold: assert property (
      @(posedge REF_CLK) disable iff (!RST_B)
      !s1_valid_ff && supply_ok |=> $stable(lpf_ff))
      else $error("low-pass changed without a sample");
   chk_rate_fast: assert property (
      @(posedge REF_CLK) disable iff (!RST_B)
      rate_code == 2'b11 |-> lo_if.quantum * 8 == ppd_pkg::LOW_QUANTUM_BASE)
      else $error("fastest rate quantum wrong");
   chk_cf_cap: assert property (
      @(posedge REF_CLK) disable iff (!RST_B)
      REG_WR && REG_ADDR == ppd_pkg::REG_CTRL && REG_WDATA[3:0] > 4'hB
      |=> cf_shift_ff == 4'hB)
      else $error("calibration ratio above 2048");
   chk_quiet_low: assert property (
      @(posedge REF_CLK) disable iff (!RST_B)
      !supply_ok [*2] |-> a_ff && b_ff && cf_ff)
      else $error("pulse issued during supply reset");
endmodule
`default_nettype wire

// File: core/ppd_pulse_gen.sv
// accumulating digital-to-frequency converter with active-low pulse
`timescale 1ns/1ps
`default_nettype none
module ppd_pulse_gen #(
   parameter logic [11:0] WIDTH = 12'h0FA
) (
   input wire logic clk,
   input wire logic rst_b,
   ppd_dfc_if.gen dfc
);
   ppd_pkg::ppd_dfc_type acc_ff;
   ppd_pkg::ppd_dfc_type nxt_acc;
   logic [11:0] cnt_ff;
   logic [11:0] nxt_cnt;
   logic pulse_b_ff;
   logic nxt_pulse_b;
   logic fired_ff;
   logic nxt_fired;
   // ---------------------------------------------------------------
   // accumulate, fire one quantum at a time
   // ---------------------------------------------------------------
   always_comb begin
      nxt_acc = acc_ff + (dfc.add_valid ? dfc.add_value : '0);
      nxt_cnt = cnt_ff;
      nxt_pulse_b = pulse_b_ff;
      nxt_fired = 1'b0;
      if (cnt_ff != 12'h000) begin
         nxt_cnt = cnt_ff - 12'h001;
         nxt_pulse_b = (cnt_ff == 12'h001);
      end else if (nxt_acc >= dfc.quantum) begin
         // one quantum gives one low pulse
         nxt_acc = nxt_acc - dfc.quantum;
         nxt_cnt = WIDTH;
         nxt_pulse_b = 1'b0;
         nxt_fired = 1'b1;
      end
      if (dfc.clr) begin
         nxt_acc = '0;
         nxt_cnt = 12'h000;
         nxt_pulse_b = 1'b1;
         nxt_fired = 1'b0;
      end
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         acc_ff <= '0;
         cnt_ff <= 12'h000;
         pulse_b_ff <= 1'b1;
         fired_ff <= 1'b0;
      end else begin
         acc_ff <= nxt_acc;
         cnt_ff <= nxt_cnt;
         pulse_b_ff <= nxt_pulse_b;
         fired_ff <= nxt_fired;
      end
   end
   assign dfc.pulse_b = pulse_b_ff;
   assign dfc.fired = fired_ff;
   chk_fire_cause: assert property (
      @(posedge clk) disable iff (!rst_b)
      fired_ff |-> $past(cnt_ff) == 12'h000 && !$past(dfc.clr))
      else $error("pulse fired while busy or cleared");
   chk_pulse_width: assert property (
      @(posedge clk) disable iff (!rst_b)
      $rose(pulse_b_ff) && !$past(dfc.clr) |-> $past(cnt_ff) == 12'h001)
      else $error("pulse released early");
endmodule
`default_nettype wire

// File: core/ppd_supply_filt.sv
// supply-low filter with hysteresis
`timescale 1ns/1ps
`default_nettype none
module ppd_supply_filt (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic supply_low,
   output logic supply_ok
);
   logic [11:0] cnt_ff;
   logic [11:0] nxt_cnt;
   logic ok_ff;
   logic nxt_ok;
   // ---------------------------------------------------------------
   // up/down integrator, trips only at the ends
   // ---------------------------------------------------------------
   always_comb begin
      nxt_cnt = cnt_ff;
      nxt_ok = ok_ff;
      if (supply_low && cnt_ff != ppd_pkg::SUPPLY_FILT_CYC) begin
         nxt_cnt = cnt_ff + 12'h001;
      end else if (!supply_low && cnt_ff != 12'h000) begin
         nxt_cnt = cnt_ff - 12'h001;
      end
      if (cnt_ff == 12'h000) begin
         nxt_ok = 1'b1;
      end else if (cnt_ff == ppd_pkg::SUPPLY_FILT_CYC) begin
         nxt_ok = 1'b0;
      end
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_ff <= ppd_pkg::SUPPLY_FILT_CYC;
         ok_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         ok_ff <= nxt_ok;
      end
   end
   assign supply_ok = ok_ff;
   chk_glitch_ignored: assert property (
      @(posedge clk) disable iff (!rst_b)
      ok_ff && supply_low && cnt_ff < ppd_pkg::SUPPLY_FILT_CYC - 12'h001
      |=> ok_ff) else $error("supply ok dropped before filter time");
   chk_trip_low: assert property (
      @(posedge clk) disable iff (!rst_b)
      supply_low [*2] ##1 (cnt_ff == ppd_pkg::SUPPLY_FILT_CYC)
      |=> !ok_ff) else $error("supply ok kept after filtered low");
endmodule
`default_nettype wire

// File: sim/ppd_pulse_counter.sv
// pulse counter model standing at the far side of the pulse outputs
`timescale 1ns/1ps
`default_nettype none
module ppd_pulse_counter (
   input wire logic clk,
   input wire logic clr,
   input wire logic cal_b,
   input wire logic low_a_b,
   input wire logic low_b_b,
   output logic [15:0] cf_count,
   output logic [15:0] low_count,
   output logic [11:0] cf_width
);
   logic cal_q = 1'b1;
   logic a_q = 1'b1;
   logic b_q = 1'b1;
   logic [11:0] run = 12'h0;
   // ----------------------------------------------------------------
   // edge counting
   // ----------------------------------------------------------------
   // counts over window
   always @(posedge clk) begin
      cal_q <= cal_b;
      a_q <= low_a_b;
      b_q <= low_b_b;
      if (clr) begin
         cf_count <= 16'h0;
         low_count <= 16'h0;
      end else begin
         if (cal_q && !cal_b) begin
            cf_count <= cf_count + 16'h1;
         end
         if ((a_q && !low_a_b) || (b_q && !low_b_b)) begin
            low_count <= low_count + 16'h1;
         end
      end
      run <= cal_b ? 12'h0 : run + 12'h1;
      if (!cal_q && cal_b) begin
         cf_width <= run;
      end
   end
endmodule
`default_nettype wire

// File: sim/testbench.sv
// self-checking bench for the power-to-pulse datapath
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic ref_clk, rst_b, sample_valid, gain_lsb, gain_msb, hpf_sel;
   logic rate_lsb, rate_msb, supply_low, reg_wr, reg_rd, cnt_clr;
   logic signed [15:0] cur_smp, volt_smp;
   logic [3:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, rd, p_off;
   logic pulse_a_b, pulse_b_b, cal_b;
   logic [15:0] cf_count, low_count;
   logic [11:0] cf_width;
   logic [31:0] pw [4];
   logic [31:0] fac [4] = '{32'h1, 32'h2, 32'h8, 32'h10};
   int n_fail = 0;
   int check_count = 0;
   int cyc = 0;

   ppd_power_to_pulse u_dut (.REF_CLK(ref_clk), .RST_B(rst_b),
      .SAMPLE_VALID(sample_valid), .CURRENT_CHANNEL(cur_smp),
      .VOLTAGE_CHANNEL(volt_smp), .GAIN_SEL_LSB(gain_lsb),
      .GAIN_SEL_MSB(gain_msb), .HPF_ENABLE_SELECT(hpf_sel),
      .RATE_SEL_LSB(rate_lsb), .RATE_SEL_MSB(rate_msb),
      .ANALOG_SUPPLY_RAIL_LOW(supply_low), .REG_ADDR(reg_addr),
      .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
      .REG_RDATA(reg_rdata), .ENERGY_PULSE_OUT_A_B(pulse_a_b),
      .ENERGY_PULSE_OUT_B_B(pulse_b_b), .CALIBRATION_PULSE_OUT_B(cal_b));
   ppd_pulse_counter u_cnt (.clk(ref_clk), .clr(cnt_clr), .cal_b(cal_b),
      .low_a_b(pulse_a_b), .low_b_b(pulse_b_b), .cf_count(cf_count),
      .low_count(low_count), .cf_width(cf_width));

   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 80000) begin
         n_fail = n_fail + 1;
         give_verdict();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count = check_count + 1;
      if (seen !== exp) begin
         n_fail = n_fail + 1;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   // read data stand one cycle; taken at the edge that ends it
   task automatic rd_get(input logic [3:0] a);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(posedge ref_clk);
      rd = reg_rdata;
   endtask

   task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
      rd_get(a);
      check(rd, exp);
   endtask

   task automatic clear_counts();
      @(posedge ref_clk);
      cnt_clr <= 1'b1;
      @(posedge ref_clk);
      cnt_clr <= 1'b0;
   endtask

   task automatic feed(input int n, input logic signed [15:0] c,
      input logic signed [15:0] v);
      @(posedge ref_clk);
      sample_valid <= 1'b1;
      cur_smp <= c;
      volt_smp <= v;
      repeat (n - 1) @(posedge ref_clk);
      @(posedge ref_clk);
      sample_valid <= 1'b0;
      repeat (8) @(posedge ref_clk);
   endtask

   task automatic restart(input logic [1:0] g, input logic h,
      input logic [1:0] r);
      @(posedge ref_clk);
      {gain_msb, gain_lsb} <= g;
      hpf_sel <= h;
      {rate_msb, rate_lsb} <= r;
      rst_b <= 1'b0;
      repeat (6) @(posedge ref_clk);
      check({29'h0, pulse_a_b, pulse_b_b, cal_b}, 32'h7);
      check(reg_rdata, 32'h0);
      rst_b <= 1'b1;
      clear_counts();
      rd_chk(ppd_pkg::REG_STATUS, {26'h0, r, g, h, 1'b0});
      repeat (2470) @(posedge ref_clk);
      rd_chk(ppd_pkg::REG_STATUS, {26'h0, r, g, h, 1'b0});
      repeat (30) @(posedge ref_clk);
      rd_chk(ppd_pkg::REG_STATUS, {26'h0, r, g, h, 1'b1});
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      rst_b = 1'b0;
      sample_valid = 1'b0;
      cur_smp = 16'h0;
      volt_smp = 16'h0;
      {gain_msb, gain_lsb, hpf_sel, rate_msb, rate_lsb} = 5'h0;
      supply_low = 1'b0;
      {reg_wr, reg_rd, cnt_clr} = 3'h0;
      reg_addr = 4'h0;
      reg_wdata = 32'h0;
      restart(2'h1, 1'b1, 2'h2);
      rd_chk(ppd_pkg::REG_CTRL, 32'hB);
      wr(ppd_pkg::REG_CTRL, 32'hF);
      rd_chk(ppd_pkg::REG_CTRL, 32'hB);
      wr(ppd_pkg::REG_CTRL, 32'h5);
      rd_chk(ppd_pkg::REG_CTRL, 32'h5);
      wr(ppd_pkg::REG_STATUS, 32'h0);
      rd_chk(ppd_pkg::REG_STATUS, 32'h27);
      rd_chk(4'h2, 32'h0);
      rd_chk(ppd_pkg::REG_LOWCNT, 32'h0);
      rd_chk(ppd_pkg::REG_POWER, 32'h0);
      $display("test registers done");
      for (int k = 0; k < 4; k++) begin
         restart(2'(k), 1'b0, 2'h0);
         feed(64, 16'sh3E8, 16'sh2710);
         rd_get(ppd_pkg::REG_POWER);
         pw[k] = rd;
         rd_chk(ppd_pkg::REG_STATUS, {26'h0, 2'h0, 2'(k), 2'h1});
      end
      for (int k = 0; k < 4; k++) begin
         check({31'h0, pw[0] > 32'h64 && pw[k] * 16 >= pw[0] * fac[k] * 15
            && pw[k] * 16 <= pw[0] * fac[k] * 17}, 32'h1);
      end
      $display("test gain done");
      restart(2'h0, 1'b0, 2'h0);
      feed(8192, 16'sh3E8, 16'sh2710);
      rd_get(ppd_pkg::REG_POWER);
      p_off = rd;
      rd_chk(ppd_pkg::REG_STATUS, 32'h1);
      restart(2'h0, 1'b1, 2'h0);
      feed(8192, 16'sh3E8, 16'sh2710);
      rd_get(ppd_pkg::REG_POWER);
      check({31'h0, p_off > 32'h0 && rd * 4 < p_off}, 32'h1);
      rd_chk(ppd_pkg::REG_STATUS, 32'h3);
      $display("test highpass done");
      restart(2'h3, 1'b0, 2'h3);
      feed(5000, 16'sh7FFF, 16'sh7FFF);
      check({31'h0, cf_count >= 16'h2}, 32'h1);
      check({16'h0, low_count}, 32'h0);
      check({20'h0, cf_width}, {20'h0, ppd_pkg::CF_PULSE_CYC});
      @(posedge ref_clk);
      supply_low <= 1'b1;
      repeat (20) @(posedge ref_clk);
      supply_low <= 1'b0;
      rd_chk(ppd_pkg::REG_STATUS, 32'h3D);
      supply_low <= 1'b1;
      feed(2600, 16'sh7FFF, 16'sh7FFF);
      clear_counts();
      feed(2000, 16'sh7FFF, 16'sh7FFF);
      check({16'h0, cf_count}, 32'h0);
      rd_chk(ppd_pkg::REG_POWER, 32'h0);
      rd_chk(ppd_pkg::REG_STATUS, 32'h3C);
      supply_low <= 1'b0;
      $display("test calibration and supply done");
      restart(2'h3, 1'b0, 2'h3);
      wr(ppd_pkg::REG_CTRL, 32'h0);
      rd_chk(ppd_pkg::REG_CTRL, 32'h0);
      clear_counts();
      feed(5000, 16'sh7FFF, 16'sh7FFF);
      check({16'h0, cf_count}, 32'h0);
      $display("test calibration scaling done");
      give_verdict();
   end
endmodule
`default_nettype wire
